//--- verilog/acc_conversion_control.sv
// converter conversion control with ahb-lite register slave
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module acc_conversion_control
    import acc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic [1:0] hresp,
    output logic [31:0] hrdata,
    // analog front end
    input wire logic cmp_above,
    input wire logic double_speed,
    output logic sample_hold,
    output logic [9:0] dac_code,
    output logic [2:0] selected_analog_input,
    output logic [7:0] pin_analog_select,
    output logic converter_power,
    output logic cpu_idle_req,
    output logic irq_req
);

    ////////////////////////////////////////////////////////////////////
    // state record

    typedef struct packed {
        acc_fsm_type st;          // sequencer
        logic [7:0] div_cnt;      // prescaler count
        logic [3:0] bit_idx;      // bit under trial
        logic [9:0] dac;          // trial code
        logic [2:0] ch;           // channel latched at start
        logic [9:0] result;       // last result
        logic [4:0] prs;          // clock_prescale
        logic [7:0] pin_cfg;      // analog_pin_config
        logic [2:0] sel;          // channel_select
        logic precision;          // precision_idle_select
        logic enable;             // converter_enable
        logic done;               // conversion_done_flag
        logic irq_en;             // converter_irq_enable
        logic gie;                // global_irq_enable
        logic wr_pend;            // write data phase due
        logic [7:0] wr_idx;       // index of pending write
        logic [31:0] rdata;       // read data for data phase
        logic ready;              // hreadyout
        logic [1:0] resp;         // hresp
        logic irq;                // irq_req
        logic idle_req;           // cpu_idle_req
        logic sh;                 // sample_hold
    } acc_regs_type;

    acc_regs_type r_reg;
    acc_regs_type r_next;

    logic [7:0] div_v;            // divisor in peripheral clocks
    logic tick;                   // one converter clock period elapsed
    logic start_req;              // accepted start this cycle

    ////////////////////////////////////////////////////////////////////
    // helpers

    // divisor from prescale field and speed mode
    function automatic logic [7:0] acc_divisor(
        input logic [4:0] prs,
        input logic x2
    );
        logic [7:0] f;
        f = x2 ? FACT_X2 : FACT_STD;
        if (prs == PRS_RST) begin
            return DIV_ZERO;
        end
        return 8'(f * {3'h0, prs});
    endfunction

    // one-hot mask of a result bit
    function automatic logic [9:0] acc_bit(input logic [3:0] idx);
        return 10'(10'h001 << idx);
    endfunction

    // converter clock tick; count restarts at each launch
    assign div_v = acc_divisor(r_reg.prs, double_speed);
    assign tick = (r_reg.div_cnt == 8'(div_v - 8'h01));

    // start only when idle, powered and pin is analog
    assign start_req = r_reg.wr_pend && (r_reg.wr_idx == IDX_CTRL)
        && hwdata[BIT_START] && hwdata[BIT_EN]
        && (r_reg.st == ST_IDLE)
        && r_reg.pin_cfg[hwdata[SEL_HI:SEL_LO]];

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [9:0] kept_v;
        logic [7:0] aidx;
        logic acc_ok;
        kept_v = r_reg.dac;
        aidx = haddr[9:2];
        acc_ok = hsel && hready && htrans[1];
        r_next = r_reg;
        r_next.ready = 1'b1;
        r_next.resp = HRESP_OKAY;

        // address phase: capture writes for the data phase
        r_next.wr_pend = acc_ok && hwrite;
        r_next.wr_idx = aidx;

        // data phase write; result bytes and unmapped ignored
        if (r_reg.wr_pend) begin
            case (r_reg.wr_idx)
                IDX_DIV: begin
                    r_next.prs = hwdata[PRS_HI:0];
                end
                IDX_CTRL: begin
                    r_next.sel = hwdata[SEL_HI:SEL_LO];
                    r_next.enable = hwdata[BIT_EN];
                    r_next.precision = hwdata[BIT_PSI];
                    // writing one leaves it; only zero clears
                    r_next.done = r_reg.done && hwdata[BIT_DONE];
                end
                IDX_CFG: begin
                    r_next.pin_cfg = hwdata[7:0];
                end
                IDX_SECOND_IRQ_ENABLE_REG: begin
                    r_next.irq_en = hwdata[BIT_IRQEN];
                end
                IDX_IEN0: begin
                    r_next.gie = hwdata[BIT_GIE];
                end
                default: begin
                    // read-only or unmapped: no effect
                end
            endcase
        end

        // prescaler runs only while converting
        if (r_reg.st != ST_IDLE) begin
            r_next.div_cnt = tick ? 8'h00 : 8'(r_reg.div_cnt + 8'h01);
        end

        // sequencer
        unique case (r_reg.st)
            ST_IDLE: begin
                if (start_req) begin
                    r_next.st = ST_SAMPLE;
                    r_next.ch = hwdata[SEL_HI:SEL_LO];
                    r_next.div_cnt = 8'h00;
                    r_next.sh = 1'b1;
                end
            end
            ST_SAMPLE: begin
                // one period of sample and hold
                if (!r_reg.enable) begin
                    r_next.st = ST_IDLE;
                    r_next.sh = 1'b0;
                end else if (tick) begin
                    r_next.st = ST_CONV;
                    r_next.sh = 1'b0;
                    r_next.dac = DAC_MID;
                    r_next.bit_idx = BIT_FIRST;
                end
            end
            ST_CONV: begin
                // one period per bit, msb first
                if (!r_reg.enable) begin
                    r_next.st = ST_IDLE;
                end else if (tick) begin
                    // input above trial keeps the bit; a rail input
                    // keeps all or none, so codes pin at the ends
                    kept_v = cmp_above ? r_reg.dac
                        : (r_reg.dac & ~acc_bit(r_reg.bit_idx));
                    if (r_reg.bit_idx == BIT_LAST) begin
                        r_next.dac = kept_v;
                        r_next.result = kept_v;
                        r_next.done = 1'b1;
                        r_next.st = ST_IDLE;
                    end else begin
                        r_next.dac = kept_v
                            | acc_bit(4'(r_reg.bit_idx - 4'h1));
                        r_next.bit_idx = 4'(r_reg.bit_idx - 4'h1);
                    end
                end
            end
            default: begin
                // illegal code: recover to idle
                r_next.st = ST_IDLE;
                r_next.sh = 1'b0;
            end
        endcase

        // request level follows the flag and both enables
        r_next.irq = r_next.done && r_next.irq_en
            && r_next.gie;
        r_next.idle_req = r_next.precision
            && (r_next.st != ST_IDLE);

        // read data from the updated state, so a read right after a
        // write sees the new value
        r_next.rdata = AHB_ZERO;
        if (acc_ok && !hwrite) begin
            case (aidx)
                IDX_DIV: begin
                    r_next.rdata[PRS_HI:0] = r_next.prs;
                end
                IDX_CTRL: begin
                    r_next.rdata[SEL_HI:SEL_LO] = r_next.sel;
                    // start bit reads as busy
                    r_next.rdata[BIT_START] =
                        (r_next.st != ST_IDLE);
                    r_next.rdata[BIT_DONE] = r_next.done;
                    r_next.rdata[BIT_EN] = r_next.enable;
                    r_next.rdata[BIT_PSI] = r_next.precision;
                end
                IDX_RES_LO: begin
                    r_next.rdata[RES_HI_LO-1:0] =
                        r_next.result[RES_HI_LO-1:0];
                end
                IDX_RES_HI: begin
                    r_next.rdata[7:0] =
                        r_next.result[RES_W-1:RES_HI_LO];
                end
                IDX_CFG: begin
                    r_next.rdata[7:0] = r_next.pin_cfg;
                end
                IDX_SECOND_IRQ_ENABLE_REG: begin
                    r_next.rdata[BIT_IRQEN] = r_next.irq_en;
                end
                IDX_IEN0: begin
                    r_next.rdata[BIT_GIE] = r_next.gie;
                end
                default: begin
                    // unmapped reads as zero
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register; clock enable freezes everything

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '{st: ST_IDLE, div_cnt: 8'h00, bit_idx: 4'h0,
                dac: RES_RST, ch: 3'h0, result: RES_RST, prs: PRS_RST,
                pin_cfg: CFG_RST, sel: 3'h0, precision: 1'b0,
                enable: 1'b0, done: 1'b0, irq_en: 1'b0, gie: 1'b0,
                wr_pend: 1'b0, wr_idx: 8'h00, rdata: AHB_ZERO,
                ready: 1'b1, resp: HRESP_OKAY, irq: 1'b0,
                idle_req: 1'b0, sh: 1'b0};
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state register

    assign hreadyout = r_reg.ready;
    assign hresp = r_reg.resp;
    assign hrdata = r_reg.rdata;
    assign sample_hold = r_reg.sh;
    assign dac_code = r_reg.dac;
    assign selected_analog_input = r_reg.ch;
    assign pin_analog_select = r_reg.pin_cfg;
    assign converter_power = r_reg.enable;
    assign cpu_idle_req = r_reg.idle_req;
    assign irq_req = r_reg.irq;

    ////////////////////////////////////////////////////////////////////
    // assertions

    default clocking acc_cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_START_LAUNCH: assert property (
        ce && start_req |=> (r_reg.st == ST_SAMPLE) && sample_hold
            ##0 (r_reg.ch == $past(hwdata[SEL_HI:SEL_LO])))
        else $error("accepted start did not launch a conversion");

    AST_BUSY_CLEAR: assert property (
        ce && r_reg.enable && (r_reg.st == ST_CONV) && tick
            && (r_reg.bit_idx == 4'h0)
        |=> (r_reg.st == ST_IDLE) && r_reg.done)
        else $error("last bit did not end the conversion with done");

    AST_DONE_STICKY: assert property (
        r_reg.done && !(r_reg.wr_pend && (r_reg.wr_idx == IDX_CTRL))
        |=> r_reg.done)
        else $error("done flag dropped without a software clear");

    AST_IRQ_LEVEL: assert property (
        irq_req == (r_reg.done && r_reg.irq_en && r_reg.gie))
        else $error("interrupt request disagrees with flag and enables");

    AST_NO_START_DIGITAL: assert property (
        ce && r_reg.wr_pend && (r_reg.wr_idx == IDX_CTRL)
            && (r_reg.st == ST_IDLE)
            && !r_reg.pin_cfg[hwdata[SEL_HI:SEL_LO]]
        |=> (r_reg.st == ST_IDLE) && !sample_hold)
        else $error("conversion started on a digital pin");

    AST_SAMPLE_PERIOD: assert property (
        ce && r_reg.enable && (r_reg.st == ST_SAMPLE) && tick
        |=> (r_reg.st == ST_CONV) && (r_reg.bit_idx == 4'h9)
            && (dac_code == 10'h200))
        else $error("sample period did not hand over to bit nine");

    AST_RESULT_TOGETHER: assert property (
        !$stable(r_reg.result)
        |-> $rose(r_reg.done) || ($past(r_reg.st) == ST_CONV))
        else $error("result changed outside a conversion end");

    AST_IGNORE_BUSY: assert property (
        (r_reg.st != ST_IDLE) ##1 (r_reg.st != ST_IDLE)
        |-> $stable(r_reg.ch))
        else $error("channel changed during a conversion");

    AST_PRESCALE_ZERO: assert property (
        (r_reg.prs == 5'h00) |-> (div_v == 8'h40))
        else $error("zero prescale does not divide by 64");

    AST_STANDBY_STOP: assert property (
        ce && !r_reg.enable |=> (r_reg.st == ST_IDLE))
        else $error("conversion kept running in standby");

    COV_CONVERSION: cover property (
        $rose(r_reg.done) && (r_reg.result == 10'h3ff));
    COV_IRQ: cover property ($rose(irq_req));
    COV_PRECISION: cover property ($rose(cpu_idle_req));
    COV_REJECTED: cover property (
        r_reg.wr_pend && (r_reg.wr_idx == IDX_CTRL)
        && hwdata[BIT_START] && (r_reg.st != ST_IDLE));

endmodule

//--- verilog/acc_pkg.sv
// constants and types of the converter conversion control block
package acc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_IEN0 = 8'ha8;
    localparam logic [7:0] IDX_SECOND_IRQ_ENABLE_REG = 8'he8;
    localparam logic [7:0] IDX_DIV = 8'hf2;
    localparam logic [7:0] IDX_CTRL = 8'hf3;
    localparam logic [7:0] IDX_RES_LO = 8'hf4;
    localparam logic [7:0] IDX_RES_HI = 8'hf5;
    localparam logic [7:0] IDX_CFG = 8'hf6;
    // converter_control fields
    localparam int SEL_LO = 0;
    localparam int SEL_HI = 2;
    localparam int BIT_START = 3;
    localparam int BIT_DONE = 4;
    localparam int BIT_EN = 5;
    localparam int BIT_PSI = 6;
    // converter_clock_divider field
    localparam int PRS_HI = 4;
    // interrupt enable bits
    localparam int BIT_IRQEN = 1;
    localparam int BIT_GIE = 7;
    // result layout
    localparam int RES_W = 10;
    localparam int RES_HI_LO = 2;
    localparam logic [3:0] BIT_FIRST = 4'h9;
    localparam logic [3:0] BIT_LAST = 4'h0;
    localparam logic [9:0] DAC_MID = 10'h200;
    // prescaler: zero divides by 64, else factor times the field
    localparam logic [7:0] DIV_ZERO = 8'h40;
    localparam logic [7:0] FACT_X2 = 8'h02;
    localparam logic [7:0] FACT_STD = 8'h04;
    // reset values
    localparam logic [4:0] PRS_RST = 5'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [9:0] RES_RST = 10'h000;
    localparam logic [31:0] AHB_ZERO = 32'h0000_0000;
    localparam logic [1:0] HRESP_OKAY = 2'h0;
    // sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONV = 3'b100
    } acc_fsm_type;
endpackage

//--- verification/acc_front_model.sv
// analog front end model: sampled channel voltages and comparator
`timescale 1ns/1ps
module acc_front_model (
    input wire logic clk,
    input wire logic [7:0][10:0] level,
    input wire logic sample_hold,
    input wire logic [9:0] dac_code,
    input wire logic [2:0] selected_analog_input,
    input wire logic [7:0] pin_analog_select,
    input wire logic converter_power,
    output logic cmp_above
);
    logic [10:0] held_reg = 11'h000; // voltage kept by sample and hold
    logic junk_reg = 1'b0; // toggles so a dead input never looks stable
    // capture the selected channel during the sample period
    always @(posedge clk) begin
        junk_reg <= ~junk_reg;
        if (sample_hold) begin
            held_reg <= level[selected_analog_input];
        end
    end
    // comparator; levels above full scale give all ones by themselves
    always_comb begin
        if (converter_power
            && pin_analog_select[selected_analog_input]) begin
            cmp_above = (held_reg >= {1'b0, dac_code});
        end else begin
            // unpowered or digital pin: output is meaningless
            cmp_above = junk_reg;
        end
    end
endmodule

//--- verification/acc_conversion_control_tb_top.sv
// self-checking bench of the conversion control block
`timescale 1ns/1ps
module acc_conversion_control_tb_top import acc_pkg::*;;
    logic clk, rst_n, ce, hsel, hwrite, double_speed, cmp_above;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, hresp;
    logic [2:0] hsize, sel_in;
    logic hreadyout, sample_hold, converter_power, cpu_idle_req, irq_req;
    logic [9:0] dac_code;
    logic [7:0] pin_sel;
    logic [7:0][10:0] level; // channel voltages, above 3ff is overrange
    int failures = 0;
    int compares = 0;
    int seed = 24768;
    int cyc = 0; // free cycle count, read only at falling edges
    int t0, n;
    // register walk after reset, last one unmapped
    localparam logic [7:0] RST_IDX [8] = '{IDX_DIV, IDX_CTRL, IDX_RES_LO,
        IDX_RES_HI, IDX_CFG, IDX_IEN0, IDX_SECOND_IRQ_ENABLE_REG, 8'h10};
    // enable writes with the request level expected afterwards
    localparam logic [7:0] IRQ_IDX [5] = '{IDX_SECOND_IRQ_ENABLE_REG, IDX_SECOND_IRQ_ENABLE_REG, IDX_IEN0,
        IDX_IEN0, IDX_CTRL};
    localparam logic [7:0] IRQ_DAT [5] = '{8'h00, 8'h02, 8'h00, 8'h80, 8'h20};
    localparam logic IRQ_EXP [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    ////////////////////////////////////////////////////////////////////////
    acc_conversion_control i_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .cmp_above(cmp_above), .double_speed(double_speed),
        .sample_hold(sample_hold), .dac_code(dac_code),
        .selected_analog_input(sel_in), .pin_analog_select(pin_sel),
        .converter_power(converter_power), .cpu_idle_req(cpu_idle_req),
        .irq_req(irq_req));
    acc_front_model i_front (.clk(clk), .level(level),
        .sample_hold(sample_hold), .dac_code(dac_code),
        .selected_analog_input(sel_in), .pin_analog_select(pin_sel),
        .converter_power(converter_power), .cmp_above(cmp_above));
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t flag %b exp %b", $time, got, exp);
        end
    endtask
    // one single word transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] idx,
        input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {22'h000000, idx, 2'b00};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk(32'(hresp), 32'(HRESP_OKAY));
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        bus(1'b1, idx, wd);
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask
    // converter clock period in system cycles
    function automatic logic [31:0] div_of(input logic [4:0] p,
        input logic x2);
        if (p == 5'h00) return 32'h40;
        return 32'(p) * (x2 ? 32'h2 : 32'h4);
    endfunction
    // wait for the request at falling edges; n counts edges since t0
    task automatic wait_done();
        int k;
        k = 0;
        while (irq_req !== 1'b1 && k < 4000) begin
            @(negedge clk);
            k++;
        end
        n = cyc - t0;
    endtask
    // code a channel level must give; overrange pins at full scale
    function automatic logic [31:0] code_of(input logic [10:0] v);
        return v > 11'h3ff ? 32'h3ff : 32'(v);
    endfunction
    // one full conversion, optionally frozen by ce for frz cycles
    task automatic conv(input logic [2:0] ch, input logic [4:0] p,
        input logic ds, input logic psi, input int frz);
        logic [31:0] res;
        res = code_of(level[ch]);
        wr(IDX_DIV, 32'(p));
        double_speed <= ds;
        rchk(IDX_DIV, 32'(p));
        wr(IDX_CTRL, {25'h0, psi, 6'h28} | 32'(ch));
        @(negedge clk);
        t0 = cyc;
        chk_flag(cpu_idle_req, psi);
        chk_flag(sample_hold, 1'b1);
        chk(32'(sel_in), 32'(ch));
        if (frz > 0) begin
            @(posedge clk);
            ce <= 1'b0;
            repeat (frz) @(posedge clk);
            ce <= 1'b1;
        end
        wait_done();
        chk(32'(n), 11 * div_of(p, ds) + 32'(frz));
        chk_flag(cpu_idle_req, 1'b0);
        chk(32'(dac_code), res);
        rchk(IDX_CTRL, {25'h0, psi, 6'h30} | 32'(ch));
        rchk(IDX_RES_HI, res >> 2);
        rchk(IDX_RES_LO, res & 32'h3);
        wr(IDX_CTRL, 32'h20 | 32'(ch));
        repeat (2) @(negedge clk);
        chk_flag(irq_req, 1'b0);
    endtask
    task automatic tally_and_finish();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // watchdog: all scenarios need well under 10000 cycles
    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        double_speed = 1'b0;
        // corners: zero, overrange, exact full scale; rest random
        level[0] = 11'h000;
        level[1] = 11'h7ff;
        level[2] = 11'h3ff;
        for (int i = 3; i < 8; i++) level[i] = 11'($random(seed)) & 11'h4ff;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        foreach (RST_IDX[i]) rchk(RST_IDX[i], 32'h0);
        wr(IDX_IEN0, 32'h80);
        wr(IDX_SECOND_IRQ_ENABLE_REG, 32'h02);
        wr(IDX_CFG, 32'hff);
        wr(IDX_CTRL, 32'h20);
        // settling time before the first start
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk(32'(pin_sel), 32'hff);
        chk_flag(converter_power, 1'b1);
        // every channel; channel 4 uses the zero prescale
        for (int i = 0; i < 8; i++) begin
            conv(3'(i), i == 4 ? 5'h00 : 5'(($random(seed) & 7) | 1),
                1'($random(seed)), 1'(i), i == 3 ? 16 : 0);
        end
        // start while busy is ignored, result stays from channel 0
        wr(IDX_DIV, 32'h1);
        wr(IDX_CTRL, 32'h28);
        @(negedge clk);
        t0 = cyc;
        rchk(IDX_CTRL, 32'h28);
        wr(IDX_CTRL, 32'h29);
        wait_done();
        chk(32'(n), 11 * div_of(5'h01, double_speed));
        chk(32'(sel_in), 32'h0);
        wr(IDX_RES_HI, 32'hff);
        wr(IDX_RES_LO, 32'h03);
        rchk(IDX_RES_HI, 32'h0);
        rchk(IDX_RES_LO, 32'h0);
        for (int k = 0; k < 5; k++) begin
            wr(IRQ_IDX[k], 32'(IRQ_DAT[k]));
            repeat (2) @(negedge clk);
            chk_flag(irq_req, IRQ_EXP[k]);
        end
        // channel 0 made digital: start has no effect
        wr(IDX_CFG, 32'hfe);
        wr(IDX_CTRL, 32'h28);
        rchk(IDX_CTRL, 32'h20);
        repeat (60) @(posedge clk);
        chk_flag(irq_req, 1'b0);
        // clearing enable mid-conversion aborts it; result kept
        wr(IDX_CTRL, 32'h29);
        wr(IDX_CTRL, 32'h09);
        repeat (60) @(posedge clk);
        rchk(IDX_CTRL, 32'h01);
        rchk(IDX_RES_HI, 32'h0);
        @(negedge clk);
        chk_flag(irq_req, 1'b0);
        chk_flag(sample_hold, 1'b0);
        // start with enable clear is refused; converter in standby
        wr(IDX_CTRL, 32'h09);
        rchk(IDX_CTRL, 32'h01);
        @(negedge clk);
        chk_flag(converter_power, 1'b0);
        tally_and_finish();
    end
endmodule
